// >>> core/dsbw_core.sv
// DDR SRAM write port with byte lane masking, read port and register slave
`timescale 1ns/10ps

// ==========================================================
// Write burst FIFO
module dsbw_fifo import dsbw_pkg::*; #(
    parameter int WIDTH = 8,
    parameter int DEPTH = DSBW_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [PW-1:0] PLAST = PW'(DEPTH - 1);
    localparam logic [CW-1:0] CFULL = CW'(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic ir_nxt, ov_nxt, push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_r[rp_r];

    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (push) begin
            wp_nxt = (wp_r == PLAST) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == PLAST) ? '0 : rp_r + 1'b1;
        end
        cnt_nxt = cnt_r + CW'(push) - CW'(pop);
        ir_nxt = (cnt_nxt != CFULL);
        ov_nxt = (cnt_nxt != '0);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            in_ready <= ir_nxt;
            out_valid <= ov_nxt;
            if (push) begin
                mem_r[wp_r] <= in_data;
            end
        end
    end
endmodule

// ==========================================================
// Top level
module dsbw_core import dsbw_pkg::*; #(
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic [DSBW_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [DSBW_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Memory pins
    input wire logic in_timing_true,
    input wire logic in_timing_inverse,
    input wire logic out_timing_true,
    input wire logic out_timing_inverse,
    input wire logic rd_port_sel_n,
    input wire logic wr_port_sel_n,
    input wire logic [3:0] lane_enable_n,
    input wire logic [AW-1:0] address,
    input wire logic [DSBW_DW-1:0] write_bus,
    output logic [DSBW_DW-1:0] output_bus,
    output logic output_bus_oe,
    // Write FIFO has room
    output logic write_ready
);
    typedef struct packed {
        logic [AW-1:0] adr;
        logic [35:0] d1;
        logic [3:0] m1;
        logic [35:0] d0;
        logic [3:0] m0;
    } dsbw_went_s;

    // ==========================================================
    // Pin synchronisers and edge detection
    logic [3:0] s1_ck, s2_ck, s3_ck, lvl_r, lvl_nxt, rise, agree;
    logic s1_rps, s2_rps, s3_rps, s1_wps, s2_wps, s3_wps;
    logic [3:0] s1_bws, s2_bws, s3_bws;
    logic [AW-1:0] s1_adr, s2_adr, s3_adr;
    logic [35:0] s1_d, s2_d, s3_d;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {s1_ck, s2_ck, s3_ck} <= '1; // Idle clocks sit high
            {s1_rps, s2_rps, s3_rps, s1_wps, s2_wps, s3_wps} <= '1;
            {s1_bws, s2_bws, s3_bws} <= '1;
            {s1_adr, s2_adr, s3_adr} <= '0;
            {s1_d, s2_d, s3_d} <= '0;
        end else begin
            s1_ck <= {out_timing_inverse, out_timing_true, in_timing_inverse, in_timing_true};
            {s1_rps, s1_wps, s1_bws, s1_adr, s1_d} <=
                {rd_port_sel_n, wr_port_sel_n, lane_enable_n, address, write_bus};
            {s2_ck, s2_rps, s2_wps, s2_bws, s2_adr, s2_d} <=
                {s1_ck, s1_rps, s1_wps, s1_bws, s1_adr, s1_d};
            {s3_ck, s3_rps, s3_wps, s3_bws, s3_adr, s3_d} <=
                {s2_ck, s2_rps, s2_wps, s2_bws, s2_adr, s2_d};
        end
    end

    always_comb begin
        agree = ~(s2_ck ^ s3_ck);
        lvl_nxt = (lvl_r & ~agree) | (s3_ck & agree);
        rise = lvl_nxt & ~lvl_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl_r <= '1;
        end else begin
            lvl_r <= lvl_nxt;
        end
    end

    // ==========================================================
    // Control register fields
    logic [3:0] ctrl_r, ctrl_nxt;
    logic [1:0] org;
    logic scm, hold, ev_inv, ev_true;
    assign org = ctrl_r[DSBW_CTRL_ORG +: 2];
    assign scm = ctrl_r[DSBW_CTRL_SCM];
    assign hold = ctrl_r[DSBW_CTRL_HOLD];
    assign ev_inv = scm ? rise[DSBW_CK_KB] : rise[DSBW_CK_CB]; // RULE11
    assign ev_true = scm ? rise[DSBW_CK_K] : rise[DSBW_CK_C]; // RULE11

    // ==========================================================
    // Write capture
    dsbw_wst_e wst_r, wst_nxt;
    dsbw_went_s went, cent;
    logic [35:0] d0_r, d0_nxt;
    logic [3:0] m0_r, m0_nxt;
    logic push, fifo_ir, fifo_ov, pop, ovf_r, ovf_nxt, clr_ovf;
    logic [31:0] wcnt_r, wcnt_nxt;

    always_comb begin
        wst_nxt = wst_r;
        d0_nxt = d0_r;
        m0_nxt = m0_r;
        push = 1'b0;
        went = '{adr: s3_adr, d1: s3_d, m1: dsbw_lane_mask(org, s3_bws), d0: d0_r, m0: m0_r};
        unique case (wst_r)
            DSBW_W_IDLE: begin
                if (rise[DSBW_CK_K] && !s3_wps) begin // RULE13 RULE15
                    d0_nxt = s3_d; // RULE10
                    m0_nxt = dsbw_lane_mask(org, s3_bws); // RULE6 RULE16
                    wst_nxt = DSBW_W_BEAT1;
                end
            end
            DSBW_W_BEAT1: begin
                if (rise[DSBW_CK_KB]) begin // RULE6 RULE10 RULE13
                    push = 1'b1;
                    wst_nxt = DSBW_W_IDLE;
                end
            end
        endcase
        ovf_nxt = (push && !fifo_ir) ? 1'b1 : (clr_ovf ? 1'b0 : ovf_r);
        wcnt_nxt = (push && fifo_ir) ? wcnt_r + 32'h1 : wcnt_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_r <= DSBW_W_IDLE;
            d0_r <= '0;
            m0_r <= '0;
            ovf_r <= 1'b0;
            wcnt_r <= '0;
        end else begin
            wst_r <= wst_nxt;
            d0_r <= d0_nxt;
            m0_r <= m0_nxt;
            ovf_r <= ovf_nxt;
            wcnt_r <= wcnt_nxt;
        end
    end

    dsbw_fifo #(.WIDTH($bits(dsbw_went_s)), .DEPTH(DSBW_FIFO_DEPTH)) dsbw_fifo_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(push),
        .in_ready(fifo_ir),
        .in_data(went),
        .out_valid(fifo_ov),
        .out_ready(!hold),
        .out_data(cent)
    );
    assign write_ready = fifo_ir;
    assign pop = fifo_ov && !hold;

    // ==========================================================
    // Array with lane masked commit
    logic [35:0] mem_r [2**(AW+1)];
    logic [35:0] b0, b1;
    assign b0 = dsbw_lane_bits(cent.m0);
    assign b1 = dsbw_lane_bits(cent.m1);

    always_ff @(posedge aclk) begin
        if (pop) begin // RULE16
            mem_r[{cent.adr, 1'b0}] <= (mem_r[{cent.adr, 1'b0}] & ~b0) | (cent.d0 & b0); // RULE8
            mem_r[{cent.adr, 1'b1}] <= (mem_r[{cent.adr, 1'b1}] & ~b1) | (cent.d1 & b1); // RULE8
        end
    end

    // ==========================================================
    // Read port
    dsbw_rst_e rst_r, rst_nxt;
    logic rq_r, rq_nxt, rq_set, oe_r, oe_nxt;
    logic [AW-1:0] rqa_r, rqa_nxt, ra_r, ra_nxt;
    logic [35:0] q_r, q_nxt;
    logic [31:0] rcnt_r, rcnt_nxt;
    assign rq_set = rise[DSBW_CK_K] && !s3_rps; // RULE14 RULE15

    always_comb begin
        rst_nxt = rst_r;
        rq_nxt = rq_r;
        rqa_nxt = rqa_r;
        ra_nxt = ra_r;
        q_nxt = q_r;
        oe_nxt = oe_r;
        rcnt_nxt = rcnt_r;
        if (rq_set) begin
            rq_nxt = 1'b1;
            rqa_nxt = s3_adr; // RULE14
            rcnt_nxt = rcnt_r + 32'h1;
        end
        unique case (rst_r)
            DSBW_R_IDLE: begin
                if (rq_r) begin
                    ra_nxt = rqa_r;
                    rst_nxt = DSBW_R_WAITK;
                    if (!rq_set) begin
                        rq_nxt = 1'b0;
                    end
                end
            end
            DSBW_R_WAITK: begin
                if (rise[DSBW_CK_K]) begin // RULE9
                    rst_nxt = DSBW_R_BEAT0;
                end
            end
            DSBW_R_BEAT0: begin
                if (ev_inv) begin // RULE14
                    q_nxt = mem_r[{ra_r, 1'b0}]; // RULE8
                    oe_nxt = 1'b1;
                    rst_nxt = DSBW_R_BEAT1;
                end
            end
            DSBW_R_BEAT1: begin
                if (ev_true) begin // RULE14
                    q_nxt = mem_r[{ra_r, 1'b1}]; // RULE8
                    rst_nxt = DSBW_R_TAIL;
                end
            end
            DSBW_R_TAIL: begin
                if (ev_inv) begin
                    oe_nxt = 1'b0;
                    rst_nxt = DSBW_R_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_r <= DSBW_R_IDLE;
            rq_r <= 1'b0;
            rqa_r <= '0;
            ra_r <= '0;
            q_r <= '0;
            oe_r <= 1'b0; // RULE7
            rcnt_r <= '0;
        end else begin
            rst_r <= rst_nxt;
            rq_r <= rq_nxt;
            rqa_r <= rqa_nxt;
            ra_r <= ra_nxt;
            q_r <= q_nxt;
            oe_r <= oe_nxt;
            rcnt_r <= rcnt_nxt;
        end
    end
    assign output_bus = q_r;
    assign output_bus_oe = oe_r;

    // ==========================================================
    // Register slave
    logic awr_r, awr_nxt, wr_r, wr_nxt, bv_r, bv_nxt, arr_r, arr_nxt, rv_r, rv_nxt;
    logic awg_r, awg_nxt, wg_r, wg_nxt;
    logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
    logic [3:0] awa_r, awa_nxt, ws_r, ws_nxt;
    logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt, stat;

    always_comb begin
        stat = '0;
        stat[DSBW_ST_WBUSY] = (wst_r != DSBW_W_IDLE);
        stat[DSBW_ST_RBUSY] = (rst_r != DSBW_R_IDLE);
        stat[DSBW_ST_EMPTY] = !fifo_ov;
        stat[DSBW_ST_FULL] = !fifo_ir;
        stat[DSBW_ST_OVF] = ovf_r;
        stat[DSBW_ST_OE] = oe_r;
        awg_nxt = awg_r | (s_axi_awvalid & awr_r);
        awa_nxt = (s_axi_awvalid && awr_r) ? s_axi_awaddr : awa_r;
        wg_nxt = wg_r | (s_axi_wvalid & wr_r);
        wd_nxt = (s_axi_wvalid && wr_r) ? s_axi_wdata : wd_r;
        ws_nxt = (s_axi_wvalid && wr_r) ? s_axi_wstrb : ws_r;
        ctrl_nxt = ctrl_r;
        clr_ovf = 1'b0;
        bv_nxt = bv_r & ~s_axi_bready;
        br_nxt = br_r;
        if (awg_r && wg_r && !bv_r) begin
            awg_nxt = 1'b0;
            wg_nxt = 1'b0;
            bv_nxt = 1'b1;
            br_nxt = DSBW_RESP_OK;
            unique case (awa_r)
                DSBW_A_CTRL: ctrl_nxt = ws_r[0] ? wd_r[3:0] : ctrl_r;
                DSBW_A_STAT: clr_ovf = ws_r[0] & wd_r[DSBW_ST_OVF];
                DSBW_A_WCNT, DSBW_A_RCNT: ;
                default: br_nxt = DSBW_RESP_ERR;
            endcase
        end
        awr_nxt = !awg_nxt && !bv_nxt;
        wr_nxt = !wg_nxt && !bv_nxt;
        rv_nxt = rv_r & ~s_axi_rready;
        rd_nxt = rd_r;
        rr_nxt = rr_r;
        if (s_axi_arvalid && arr_r) begin
            rv_nxt = 1'b1;
            rr_nxt = DSBW_RESP_OK;
            unique case (s_axi_araddr)
                DSBW_A_CTRL: rd_nxt = {28'h0, ctrl_r};
                DSBW_A_STAT: rd_nxt = stat;
                DSBW_A_WCNT: rd_nxt = wcnt_r;
                DSBW_A_RCNT: rd_nxt = rcnt_r;
                default: begin
                    rd_nxt = '0;
                    rr_nxt = DSBW_RESP_ERR;
                end
            endcase
        end
        arr_nxt = !rv_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {awr_r, wr_r, arr_r} <= 3'h7;
            {bv_r, rv_r, awg_r, wg_r} <= 4'h0;
            {br_r, rr_r} <= 4'h0;
            {awa_r, ws_r, wd_r, rd_r} <= '0;
            ctrl_r <= DSBW_CTRL_RST;
        end else begin
            {awr_r, wr_r, arr_r} <= {awr_nxt, wr_nxt, arr_nxt};
            {bv_r, rv_r, awg_r, wg_r} <= {bv_nxt, rv_nxt, awg_nxt, wg_nxt};
            {br_r, rr_r} <= {br_nxt, rr_nxt};
            {awa_r, ws_r, wd_r, rd_r} <= {awa_nxt, ws_nxt, wd_nxt, rd_nxt};
            ctrl_r <= ctrl_nxt;
        end
    end
    assign {s_axi_awready, s_axi_wready, s_axi_arready} = {awr_r, wr_r, arr_r};
    assign {s_axi_bvalid, s_axi_bresp, s_axi_rvalid, s_axi_rresp} = {bv_r, br_r, rv_r, rr_r};
    assign s_axi_rdata = rd_r;

    // ==========================================================
    // Checks
    logic chk_v_r;
    logic [AW:0] chk_i_r;
    logic [35:0] chk_old_r, chk_d_r, chk_b_r;
    always_ff @(posedge aclk) begin
        chk_v_r <= aresetn && pop;
        chk_i_r <= {cent.adr, 1'b0};
        chk_old_r <= mem_r[{cent.adr, 1'b0}];
        chk_d_r <= cent.d0;
        chk_b_r <= b0;
    end

    property p_oe_reset;
        @(posedge aclk) disable iff (!aresetn)
        $rose(aresetn) |-> !output_bus_oe && rst_r == DSBW_R_IDLE;
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("bus driven after reset"); // RULE7

    property p_lane_commit;
        @(posedge aclk) disable iff (!aresetn)
        chk_v_r |-> (((mem_r[chk_i_r] ^ chk_d_r) & chk_b_r) == '0)
            && (((mem_r[chk_i_r] ^ chk_old_r) & ~chk_b_r) == '0);
    endproperty
    a_lane_commit: assert property (p_lane_commit) else $error("lane mask misapplied"); // RULE5

    property p_org9_mask;
        @(posedge aclk) disable iff (!aresetn)
        push && org == DSBW_ORG9 |-> went.m1[3:1] == 3'h0 && went.m0[3:1] == 3'h0;
    endproperty
    a_org9_mask: assert property (p_org9_mask) else $error("extra lane in 9-bit mode"); // RULE3

    property p_org18_mask;
        @(posedge aclk) disable iff (!aresetn)
        push && org == DSBW_ORG18 |-> went.m1[3:2] == 2'h0 && went.m0[3:2] == 2'h0;
    endproperty
    a_org18_mask: assert property (p_org18_mask) else $error("extra lane in 18-bit mode"); // RULE1

    property p_first_beat;
        @(posedge aclk) disable iff (!aresetn)
        rise[DSBW_CK_K] && !s3_wps && wst_r == DSBW_W_IDLE
            |=> wst_r == DSBW_W_BEAT1 && d0_r == $past(s3_d);
    endproperty
    a_first_beat: assert property (p_first_beat) else $error("first beat missed"); // RULE13

    property p_push_edge;
        @(posedge aclk) disable iff (!aresetn)
        push |-> rise[DSBW_CK_KB] && wst_r == DSBW_W_BEAT1;
    endproperty
    a_push_edge: assert property (p_push_edge) else $error("beat two off inverse edge"); // RULE10

    property p_out_edge;
        @(posedge aclk) disable iff (!aresetn)
        $changed(output_bus) || $changed(output_bus_oe) |-> $past(ev_inv || ev_true);
    endproperty
    a_out_edge: assert property (p_out_edge) else $error("output moved off clock edge"); // RULE11

    property p_wait_k;
        @(posedge aclk) disable iff (!aresetn)
        rst_r == DSBW_R_WAITK && !rise[DSBW_CK_K] |=> rst_r == DSBW_R_WAITK;
    endproperty
    a_wait_k: assert property (p_wait_k) else $error("read beat before t+1"); // RULE9

    property p_sel_on_k;
        @(posedge aclk) disable iff (!aresetn)
        $rose(rq_r) |-> $past(rise[DSBW_CK_K]) && !$past(s3_rps);
    endproperty
    a_sel_on_k: assert property (p_sel_on_k) else $error("select sampled off edge"); // RULE15

    property p_bvalid_hold;
        @(posedge aclk) disable iff (!aresetn)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");
endmodule

// >>> core/dsbw_pkg.sv
// Constants, types and lane decoding for the DDR SRAM byte write block
// Notes on behaviour
// [RULE1] 18-bit: enable bit 0 gates bits 8:0, bit 1 gates 17:9.
// [RULE2] 18-bit: both enables high writes nothing for that beat.
// [RULE3] 9-bit: one enable; low stores bits 8:0, high stores nothing.
// [RULE4] 36-bit: all four enables low stores the whole beat.
// [RULE5] 36-bit: each enable gates its own 9-bit lane; all high stores nothing.
// [RULE6] Enables sampled per beat, first on true edge, second on inverse edge.
// [RULE7] After power-up deselected, output bus not driven until a read.
// [RULE8] Address latched at start; first beat offset zero, second offset one.
// [RULE9] Cycle t starts an access; t+1 and t+2 follow it.
// [RULE10] Write beats are registered on the two input timing clock edges.
// [RULE11] Read beats leave on output clock edges, or input clocks in single mode.
// [RULE12] Controller should park all timing clocks high when stopping them.
// [RULE13] Write starts on true edge with select low; address on inverse edge.
// [RULE14] Read latches address at start; beats at t+1 inverse and t+2 true.
// [RULE15] Port selects sampled on true edge only; pending accesses complete.
// [RULE16] Enables registered with each beat, applied when the burst commits.
package dsbw_pkg;
    localparam int DSBW_DW = 36;
    localparam int DSBW_LANES = 4;
    localparam int DSBW_LW = 9;
    localparam int DSBW_FIFO_DEPTH = 8;
    localparam int DSBW_AXI_AW = 4;
    // Register byte offsets
    localparam logic [3:0] DSBW_A_CTRL = 4'h0;
    localparam logic [3:0] DSBW_A_STAT = 4'h4;
    localparam logic [3:0] DSBW_A_WCNT = 4'h8;
    localparam logic [3:0] DSBW_A_RCNT = 4'hc;
    // Control fields and reset value
    localparam logic [3:0] DSBW_CTRL_RST = 4'h2;
    localparam int DSBW_CTRL_ORG = 0;
    localparam int DSBW_CTRL_SCM = 2;
    localparam int DSBW_CTRL_HOLD = 3;
    // Status fields
    localparam int DSBW_ST_WBUSY = 0;
    localparam int DSBW_ST_RBUSY = 1;
    localparam int DSBW_ST_EMPTY = 2;
    localparam int DSBW_ST_FULL = 3;
    localparam int DSBW_ST_OVF = 4;
    localparam int DSBW_ST_OE = 5;
    // Timing clock positions
    localparam int DSBW_CK_K = 0;
    localparam int DSBW_CK_KB = 1;
    localparam int DSBW_CK_C = 2;
    localparam int DSBW_CK_CB = 3;
    // Organisations and bus answers
    localparam logic [1:0] DSBW_ORG9 = 2'h0;
    localparam logic [1:0] DSBW_ORG18 = 2'h1;
    localparam logic [1:0] DSBW_RESP_OK = 2'h0;
    localparam logic [1:0] DSBW_RESP_ERR = 2'h2;

    typedef enum logic {DSBW_W_IDLE, DSBW_W_BEAT1} dsbw_wst_e;
    typedef enum logic [2:0] {
        DSBW_R_IDLE, DSBW_R_WAITK, DSBW_R_BEAT0, DSBW_R_BEAT1, DSBW_R_TAIL
    } dsbw_rst_e;

    function automatic logic [3:0] dsbw_lane_mask(input logic [1:0] org,
                                                  input logic [3:0] en_n);
        unique case (org)
            DSBW_ORG9: dsbw_lane_mask = {3'h0, ~en_n[0]}; // RULE3
            DSBW_ORG18: dsbw_lane_mask = {2'h0, ~en_n[1:0]}; // RULE1 RULE2
            default: dsbw_lane_mask = ~en_n; // RULE4 RULE5
        endcase
    endfunction

    function automatic logic [35:0] dsbw_lane_bits(input logic [3:0] m);
        logic [35:0] b;
        b = '0;
        for (int l = 0; l < DSBW_LANES; l++) begin
            b[l*DSBW_LW +: DSBW_LW] = {DSBW_LW{m[l]}};
        end
        return b;
    endfunction
endpackage

// >>> tb/dsbw_ctl_model.sv
// Memory controller model driving the SRAM write and read pins
`timescale 1ns/10ps
module dsbw_ctl_model import dsbw_pkg::*; #(
    parameter int HALF = 6
) (
    // Clock and read side
    input wire logic aclk,
    input wire logic [DSBW_DW-1:0] output_bus,
    input wire logic output_bus_oe,
    // Pins
    output logic k,
    output logic kb,
    output logic rsel_n,
    output logic wsel_n,
    output logic [3:0] en_n,
    output logic [3:0] addr,
    output logic [DSBW_DW-1:0] wdata
);
    // ====================
    // Pin sequencing
    logic [DSBW_DW-1:0] q_k, q_kb;
    logic oe_k, oe_kb;
    initial begin
        {k, kb, rsel_n, wsel_n, en_n, addr, wdata} = '1;
    end
    task automatic wait_half(output logic [DSBW_DW-1:0] q, output logic oe);
        repeat (HALF - 1) @(posedge aclk);
        @(negedge aclk);
        q = output_bus;
        oe = output_bus_oe;
        @(posedge aclk);
    endtask
    task automatic start;
        k <= 1'h0;
        wait_half(q_kb, oe_kb);
    endtask
    task automatic cyc(input logic ws, rs, input logic [3:0] a, e0, e1,
                       input logic [DSBW_DW-1:0] d0, d1);
        {wsel_n, rsel_n, addr, en_n, wdata} <= {ws, rs, a, e0, d0};
        {k, kb} <= 2'h2;
        wait_half(q_k, oe_k);
        {wsel_n, rsel_n, en_n, wdata} <= {2'h3, e1, d1};
        {k, kb} <= 2'h1;
        wait_half(q_kb, oe_kb);
    endtask
    task automatic nop;
        cyc(1'h1, 1'h1, addr, 4'hf, 4'hf, ~wdata, wdata);
    endtask
    task automatic park;
        {k, rsel_n, wsel_n, wdata} <= {3'h7, ~wdata};
        wait_half(q_k, oe_k);
    endtask
endmodule

// >>> tb/dsbw_core_tb_top.sv
// Self-checking bench for the byte-lane write masking block
`timescale 1ns/10ps
module dsbw_core_tb_top import dsbw_pkg::*;;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [3:0] awaddr = '0, araddr = '0, wstrb = 4'hf;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdat = '0;
    logic [31:0] rdata;
    logic awready, wready, bvalid, arready, rvalid, oe, wr_rdy, k, kb, rs, ws;
    logic [1:0] bresp, rresp;
    logic [1:0] org = 2'h2;
    logic [3:0] en, ad;
    logic [DSBW_DW-1:0] qbus, dbus;
    logic [DSBW_DW-1:0] exp_mem [32];
    int num_errors = 0, n_tests = 0, nw = 0, nr = 0;
    always #2.5 aclk = ~aclk;

    dsbw_core dsbw_core_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdat),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .in_timing_true(k), .in_timing_inverse(kb), .out_timing_true(k),
        .out_timing_inverse(kb), .rd_port_sel_n(rs), .wr_port_sel_n(ws), .lane_enable_n(en),
        .address(ad), .write_bus(dbus), .output_bus(qbus), .output_bus_oe(oe),
        .write_ready(wr_rdy));
    dsbw_ctl_model dsbw_ctl_model_i (.aclk(aclk), .output_bus(qbus), .output_bus_oe(oe), .k(k),
        .kb(kb), .rsel_n(rs), .wsel_n(ws), .en_n(en), .addr(ad), .wdata(dbus));

    // ====================
    // Shared tasks
    task automatic finish_test;
        $display("Checks %0d, errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [DSBW_DW-1:0] got, input logic [DSBW_DW-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 50) begin
            num_errors++;
            finish_test;
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        {awaddr, wdat, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 50);
        bready <= 1'h0;
        tmo(n);
        chk(36'(bresp), 36'(er));
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 50);
        {d, r} = {rdata, rresp};
        rready <= 1'h0;
        tmo(n);
    endtask
    function automatic logic [DSBW_DW-1:0] merge(input logic [DSBW_DW-1:0] o, d,
                                                 input logic [3:0] e);
        merge = o;
        for (int l = 0; l < 4; l++) begin
            if (!e[l] && (org > 2'h1 || l == 0 || (org == 2'h1 && l == 1))) begin
                merge[l*9 +: 9] = d[l*9 +: 9];
            end
        end
    endfunction
    task automatic wr(input logic [3:0] a, e0, e1, input logic [DSBW_DW-1:0] d0, d1);
        dsbw_ctl_model_i.start;
        dsbw_ctl_model_i.cyc(1'h0, 1'h1, a, e0, e1, d0, d1);
        dsbw_ctl_model_i.park;
        exp_mem[{a, 1'h0}] = merge(exp_mem[{a, 1'h0}], d0, e0);
        exp_mem[{a, 1'h1}] = merge(exp_mem[{a, 1'h1}], d1, e1);
        nw++;
    endtask
    task automatic rd(input logic [3:0] a);
        logic [DSBW_DW-1:0] b0;
        logic oe0;
        dsbw_ctl_model_i.start;
        dsbw_ctl_model_i.cyc(1'h1, 1'h0, a, 4'hf, 4'hf, '0, '1);
        dsbw_ctl_model_i.nop;
        {b0, oe0} = {dsbw_ctl_model_i.q_kb, dsbw_ctl_model_i.oe_kb};
        dsbw_ctl_model_i.nop;
        chk(b0, exp_mem[{a, 1'h0}]);
        chk(dsbw_ctl_model_i.q_k, exp_mem[{a, 1'h1}]);
        chk(36'({oe0, dsbw_ctl_model_i.oe_kb}), 36'h2);
        dsbw_ctl_model_i.park;
        nr++;
    endtask

    // ====================
    // Scenarios
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        chk(36'({oe, wr_rdy}), 36'h1);
        axi_rd(DSBW_A_CTRL, d, r);
        chk(36'(d), 36'h2);
        wr(4'h1, 4'h0, 4'h0, 36'h123456789, 36'hfedcba987);
        wr(4'h2, 4'h0, 4'h0, 36'h0aaaaaaaa, 36'h955555555);
        rd(4'h1);
        wr(4'h1, 4'ha, 4'hf, 36'hf0f0f0f0f, 36'h0);
        rd(4'h1);
        axi_wr(DSBW_A_CTRL, 32'h5, DSBW_RESP_OK);
        org = 2'h1;
        wr(4'h2, 4'h2, 4'h3, 36'h3ffffffff, 36'h0);
        rd(4'h2);
        axi_wr(DSBW_A_CTRL, 32'h0, DSBW_RESP_OK);
        org = 2'h0;
        wr(4'h2, 4'he, 4'h1, 36'h0, 36'h3ffffffff);
        rd(4'h2);
        // Fill the FIFO past full while commits are held, then drain
        axi_wr(DSBW_A_CTRL, 32'ha, DSBW_RESP_OK);
        org = 2'h2;
        repeat (9) wr(4'h0, 4'hf, 4'hf, 36'h0, 36'h0);
        nw--;
        axi_rd(DSBW_A_STAT, d, r);
        chk(36'({wr_rdy, d[4:2]}), 36'h6);
        axi_rd(DSBW_A_WCNT, d, r);
        chk(36'(d), 36'(nw));
        axi_wr(DSBW_A_CTRL, 32'h2, DSBW_RESP_OK);
        d = '0;
        for (int i = 0; i < 20 && d[2] !== 1'h1; i++) axi_rd(DSBW_A_STAT, d, r);
        chk(36'(d[4:2]), 36'h5);
        axi_wr(DSBW_A_STAT, 32'h10, DSBW_RESP_OK);
        axi_rd(DSBW_A_STAT, d, r);
        chk(36'(d[4:2]), 36'h1);
        axi_rd(4'h2, d, r);
        chk(36'({d, r}), 36'(DSBW_RESP_ERR));
        axi_wr(4'h6, 32'h1, DSBW_RESP_ERR);
        axi_rd(DSBW_A_RCNT, d, r);
        chk(36'(d), 36'(nr));
        finish_test;
    end
endmodule
